// [design/llfi_consts.svh]
// Offsets, field positions, reset values and fault codes of the fault-injection block
// What this block does
// - Flag the next received control packet of the chosen class as CRC-failed.
// - A rising forced-replay bit starts one retransmission of the retry buffer.
// - Send NAK instead of ACK with same, incremented or decremented sequence.
// - While set, corrupt the end-to-end CRC of every transmitted transaction packet.
// - While set, corrupt the link CRC of every transmitted transaction packet.
// - Send a bad CRC on transmitted control packets of the chosen class.
// - Credit codes 00001 to 11000 adjust the allocation by one on each extraction.
// - Posted codes: 00000 normal, 00001 header, 00010 data, 00011 both plus one.
// - Non-posted codes: 00100 header plus one, 00101 data plus one.
// - Completion codes: 00111 header plus one, 01000 data plus one.
// - Code 01010 removes one posted header credit; other decrements as coded.
// - In eight-lane mode the link-layer fields are ignored.
`ifndef LLFI_CONSTS_SVH
`define LLFI_CONSTS_SVH

`define LLFI_OFS_VECTOR   4'h0
`define LLFI_OFS_STATUS   4'h4
`define LLFI_OFS_CONFIG   4'h8

`define LLFI_RXCRC_LSB    15
`define LLFI_RXCRC_MSB    16
`define LLFI_REPLAY_BIT   17
`define LLFI_ACKNAK_LSB   18
`define LLFI_ACKNAK_MSB   19
`define LLFI_ECRC_BIT     20
`define LLFI_LCRC_BIT     21
`define LLFI_TXCRC_LSB    22
`define LLFI_TXCRC_MSB    23
`define LLFI_CREDIT_LSB   24
`define LLFI_CREDIT_MSB   28

`define LLFI_X8_MASK      32'hFF10_7FFF
`define LLFI_VECTOR_RST   32'h0000_0000
`define LLFI_CONFIG_X8    0
`define LLFI_CONFIG_ARMED 8

`define LLFI_CODE_OFF     2'h0
`define LLFI_RX_ACK       2'h1
`define LLFI_RX_PM        2'h2
`define LLFI_RX_FC        2'h3
`define LLFI_TX_PM        2'h1
`define LLFI_TX_FC        2'h2
`define LLFI_TX_ACK       2'h3
`define LLFI_ACK_SAME     2'h1
`define LLFI_ACK_INC      2'h2
`define LLFI_ACK_DEC      2'h3

`endif

// [design/llfi_credit_adj.sv]
// Credit-error code decoder and one-credit adjustment of an allocation update
`timescale 1ns/1ps
module llfi_credit_adj
	import llfi_pkg::*;
(
	input  wire logic [4:0]  code,
	input  wire llfi_cls_t   cls,
	input  wire logic [7:0]  hdrIn,
	input  wire logic [11:0] dataIn,
	output logic      [7:0]  hdrOut,
	output logic      [11:0] dataOut,
	output logic             adjusted
);
	llfi_cls_t   codeCls;
	llfi_delta_t hdrDelta;
	llfi_delta_t dataDelta;
	logic [11:0] hdrWide;

	function automatic logic [11:0] llfi_apply(input logic [11:0] v, input llfi_delta_t d);
		case (d)
			LLFI_DELTA_PLUS:  llfi_apply = v + 12'h001;
			LLFI_DELTA_MINUS: llfi_apply = v - 12'h001;
			default:          llfi_apply = v;
		endcase
	endfunction : llfi_apply

	always_comb begin
		codeCls   = LLFI_CLS_NONE;
		hdrDelta  = LLFI_DELTA_ZERO;
		dataDelta = LLFI_DELTA_ZERO;
		case (code)
			5'h01: begin codeCls = LLFI_CLS_POSTED;     hdrDelta = LLFI_DELTA_PLUS; end
			5'h02: begin codeCls = LLFI_CLS_POSTED;     dataDelta = LLFI_DELTA_PLUS; end
			5'h03: begin codeCls = LLFI_CLS_POSTED;     hdrDelta = LLFI_DELTA_PLUS;
				dataDelta = LLFI_DELTA_PLUS; end
			5'h04: begin codeCls = LLFI_CLS_NONPOSTED;  hdrDelta = LLFI_DELTA_PLUS; end
			5'h05: begin codeCls = LLFI_CLS_NONPOSTED;  dataDelta = LLFI_DELTA_PLUS; end
			5'h06: begin codeCls = LLFI_CLS_NONPOSTED;  hdrDelta = LLFI_DELTA_PLUS;
				dataDelta = LLFI_DELTA_PLUS; end
			5'h07: begin codeCls = LLFI_CLS_COMPLETION; hdrDelta = LLFI_DELTA_PLUS; end
			5'h08: begin codeCls = LLFI_CLS_COMPLETION; dataDelta = LLFI_DELTA_PLUS; end
			5'h09: begin codeCls = LLFI_CLS_COMPLETION; hdrDelta = LLFI_DELTA_PLUS;
				dataDelta = LLFI_DELTA_PLUS; end
			5'h0A: begin codeCls = LLFI_CLS_POSTED;     hdrDelta = LLFI_DELTA_MINUS; end
			5'h0B: begin codeCls = LLFI_CLS_POSTED;     dataDelta = LLFI_DELTA_MINUS; end
			5'h0C: begin codeCls = LLFI_CLS_POSTED;     hdrDelta = LLFI_DELTA_MINUS;
				dataDelta = LLFI_DELTA_MINUS; end
			5'h0D: begin codeCls = LLFI_CLS_NONPOSTED;  hdrDelta = LLFI_DELTA_MINUS; end
			5'h0E: begin codeCls = LLFI_CLS_NONPOSTED;  dataDelta = LLFI_DELTA_MINUS; end
			5'h0F: begin codeCls = LLFI_CLS_NONPOSTED;  hdrDelta = LLFI_DELTA_MINUS;
				dataDelta = LLFI_DELTA_MINUS; end
			5'h10: begin codeCls = LLFI_CLS_COMPLETION; hdrDelta = LLFI_DELTA_MINUS; end
			5'h11: begin codeCls = LLFI_CLS_COMPLETION; dataDelta = LLFI_DELTA_MINUS; end
			5'h12: begin codeCls = LLFI_CLS_COMPLETION; hdrDelta = LLFI_DELTA_MINUS;
				dataDelta = LLFI_DELTA_MINUS; end
			5'h13: begin codeCls = LLFI_CLS_POSTED;     hdrDelta = LLFI_DELTA_PLUS;
				dataDelta = LLFI_DELTA_MINUS; end
			5'h14: begin codeCls = LLFI_CLS_POSTED;     hdrDelta = LLFI_DELTA_MINUS;
				dataDelta = LLFI_DELTA_PLUS; end
			5'h15: begin codeCls = LLFI_CLS_NONPOSTED;  hdrDelta = LLFI_DELTA_PLUS;
				dataDelta = LLFI_DELTA_MINUS; end
			5'h16: begin codeCls = LLFI_CLS_NONPOSTED;  hdrDelta = LLFI_DELTA_MINUS;
				dataDelta = LLFI_DELTA_PLUS; end
			5'h17: begin codeCls = LLFI_CLS_COMPLETION; hdrDelta = LLFI_DELTA_PLUS;
				dataDelta = LLFI_DELTA_MINUS; end
			5'h18: begin codeCls = LLFI_CLS_COMPLETION; hdrDelta = LLFI_DELTA_MINUS;
				dataDelta = LLFI_DELTA_PLUS; end
			default: begin codeCls = LLFI_CLS_NONE; end
		endcase
	end

	// Only the class named by the code is touched; other traffic keeps its normal update
	always_comb begin
		adjusted = (codeCls != LLFI_CLS_NONE) && (codeCls == cls);
		hdrWide  = llfi_apply({4'h0, hdrIn}, adjusted ? hdrDelta : LLFI_DELTA_ZERO);
		hdrOut   = hdrWide[7:0];
		dataOut  = llfi_apply(dataIn, adjusted ? dataDelta : LLFI_DELTA_ZERO);
	end
endmodule : llfi_credit_adj

// [design/llfi_pkg.sv]
// Types shared by the fault-injection block
package llfi_pkg;
	typedef enum logic [1:0] {
		LLFI_DLLP_ACKNAK,
		LLFI_DLLP_PM,
		LLFI_DLLP_FC,
		LLFI_DLLP_OTHER
	} llfi_dllp_t;

	typedef enum logic [1:0] {
		LLFI_CLS_POSTED,
		LLFI_CLS_NONPOSTED,
		LLFI_CLS_COMPLETION,
		LLFI_CLS_NONE
	} llfi_cls_t;

	typedef enum logic [1:0] {
		LLFI_DELTA_ZERO,
		LLFI_DELTA_PLUS,
		LLFI_DELTA_MINUS
	} llfi_delta_t;
endpackage : llfi_pkg

// [design/llfi_top.sv]
// Link-layer fault injection: register slave, control-packet and credit corruption paths
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "llfi_consts.svh"
module llfi_top
	import llfi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rxDllpValid,
	input  wire llfi_dllp_t  rxDllpType,
	input  wire logic        rxDllpCrcOk,
	output logic             rxDllpValidOut,
	output logic             rxDllpCrcError,
	output logic             replayStart,
	input  wire logic        ackValid,
	input  wire logic [11:0] ackSeq,
	output logic             ackValidOut,
	output logic             ackIsNak,
	output logic      [11:0] ackSeqOut,
	input  wire logic        txTlpValid,
	input  wire logic [31:0] txEcrc,
	input  wire logic [31:0] txLcrc,
	output logic             txTlpValidOut,
	output logic      [31:0] txEcrcOut,
	output logic      [31:0] txLcrcOut,
	input  wire logic        txDllpValid,
	input  wire llfi_dllp_t  txDllpType,
	input  wire logic [15:0] txDllpCrc,
	output logic             txDllpValidOut,
	output logic      [15:0] txDllpCrcOut,
	input  wire logic        creditEvent,
	input  wire llfi_cls_t   creditClass,
	input  wire logic [7:0]  creditHdr,
	input  wire logic [11:0] creditData,
	output logic             postedCreditUpdate,
	output logic             nonpostedCreditUpdate,
	output logic             completionCreditUpdate,
	output logic      [7:0]  creditHdrOut,
	output logic      [11:0] creditDataOut
);
	logic [31:0] faultVector;
	logic        x8Mode;
	logic        rxArmed;
	logic        replayLast;
	logic [7:0]  rxForcedCount;
	logic [7:0]  nakCount;
	logic [7:0]  txCorruptCount;
	logic [7:0]  creditAdjCount;

	logic [31:0] effVector;
	logic [1:0]  rxCrcCode;
	logic [1:0]  ackCode;
	logic [1:0]  txCrcCode;
	logic [4:0]  creditCode;
	logic        replayBit;
	logic        ecrcBit;
	logic        lcrcBit;
	logic        busWrite;
	logic        busRead;
	logic        rxHit;
	logic        txHit;
	logic        ackSubst;
	logic        next_armed;
	logic [7:0]  adjHdr;
	logic [11:0] adjData;
	logic        adjDone;

	// Decode of a two-bit class selector against a packet type
	function automatic logic llfi_cls_hit(input logic [1:0] sel, input llfi_dllp_t t,
		input logic [1:0] ackSel, input logic [1:0] pmSel, input logic [1:0] fcSel);
		llfi_cls_hit = (sel != `LLFI_CODE_OFF) &&
			(((sel == ackSel) && (t == LLFI_DLLP_ACKNAK)) ||
			 ((sel == pmSel) && (t == LLFI_DLLP_PM)) ||
			 ((sel == fcSel) && (t == LLFI_DLLP_FC)));
	endfunction : llfi_cls_hit

	// The eight-lane mode bit keeps only ECRC and credit fields alive
	always_comb begin
		effVector  = x8Mode ? (faultVector & `LLFI_X8_MASK) : faultVector;
		rxCrcCode  = effVector[`LLFI_RXCRC_MSB:`LLFI_RXCRC_LSB];
		replayBit  = effVector[`LLFI_REPLAY_BIT];
		ackCode    = effVector[`LLFI_ACKNAK_MSB:`LLFI_ACKNAK_LSB];
		ecrcBit    = effVector[`LLFI_ECRC_BIT];
		lcrcBit    = effVector[`LLFI_LCRC_BIT];
		txCrcCode  = effVector[`LLFI_TXCRC_MSB:`LLFI_TXCRC_LSB];
		creditCode = effVector[`LLFI_CREDIT_MSB:`LLFI_CREDIT_LSB];
	end

	always_comb begin
		busWrite = avs_write && !avs_waitrequest;
		busRead  = avs_read && avs_waitrequest;
		rxHit    = rxDllpValid && rxArmed &&
			llfi_cls_hit(rxCrcCode, rxDllpType, `LLFI_RX_ACK, `LLFI_RX_PM, `LLFI_RX_FC);
		txHit    = txDllpValid &&
			llfi_cls_hit(txCrcCode, txDllpType, `LLFI_TX_ACK, `LLFI_TX_PM, `LLFI_TX_FC);
		ackSubst = ackValid && (ackCode != `LLFI_CODE_OFF);
	end

	// One wait cycle per access: read data is loaded while waitrequest is high
	always_ff @(posedge clk) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_waitrequest && (avs_read || avs_write)) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (busRead) begin
			case (avs_address)
				`LLFI_OFS_VECTOR: avs_readdata <= faultVector;
				`LLFI_OFS_STATUS: avs_readdata <= {creditAdjCount, txCorruptCount,
					nakCount, rxForcedCount};
				`LLFI_OFS_CONFIG: avs_readdata <= {23'h000000, rxArmed, 7'h00, x8Mode};
				default:          avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// The vector is a register on the core clock, so every path sees a stable value
	always_ff @(posedge clk) begin
		if (!resetn) begin
			faultVector <= `LLFI_VECTOR_RST;
		end else if (busWrite && (avs_address == `LLFI_OFS_VECTOR)) begin
			faultVector <= avs_writedata;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			x8Mode <= 1'b0;
		end else if (busWrite && (avs_address == `LLFI_OFS_CONFIG)) begin
			x8Mode <= avs_writedata[`LLFI_CONFIG_X8];
		end
	end

	// Arming follows each vector write; a packet hit in the same cycle as a rewrite
	// leaves the block armed again, so a fresh request is never swallowed
	always_comb begin
		next_armed = rxArmed;
		// Zero field and hit come first so that a vector write always wins
		if (rxCrcCode == `LLFI_CODE_OFF) begin
			next_armed = 1'b0;
		end
		if (rxHit) begin
			next_armed = 1'b0;
		end
		if (busWrite && (avs_address == `LLFI_OFS_VECTOR)) begin
			next_armed = (avs_writedata[`LLFI_RXCRC_MSB:`LLFI_RXCRC_LSB] != `LLFI_CODE_OFF);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxArmed <= 1'b0;
		end else begin
			rxArmed <= next_armed;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxDllpValidOut <= 1'b0;
		end else begin
			rxDllpValidOut <= rxDllpValid;
		end
	end

	// A real CRC failure is passed on even when no forced error is pending
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxDllpCrcError <= 1'b0;
		end else begin
			rxDllpCrcError <= rxDllpValid && (!rxDllpCrcOk || rxHit);
		end
	end

	// Edge of the replay bit, so a held bit asks for one retry only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			replayLast <= 1'b0;
		end else begin
			replayLast <= replayBit;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			replayStart <= 1'b0;
		end else begin
			replayStart <= replayBit && !replayLast;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ackValidOut <= 1'b0;
		end else begin
			ackValidOut <= ackValid;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ackIsNak <= 1'b0;
		end else begin
			ackIsNak <= ackSubst;
		end
	end

	// Sequence arithmetic wraps at twelve bits, like the sequence space itself
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ackSeqOut <= 12'h000;
		end else begin
			case (ackSubst ? ackCode : `LLFI_CODE_OFF)
				`LLFI_ACK_INC: ackSeqOut <= ackSeq + 12'h001;
				`LLFI_ACK_DEC: ackSeqOut <= ackSeq - 12'h001;
				default:       ackSeqOut <= ackSeq;
			endcase
		end
	end

	// Inverting the whole CRC guarantees a mismatch whatever the payload
	always_ff @(posedge clk) begin
		if (!resetn) begin
			txTlpValidOut <= 1'b0;
		end else begin
			txTlpValidOut <= txTlpValid;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			txEcrcOut <= 32'h0000_0000;
		end else begin
			txEcrcOut <= ecrcBit ? ~txEcrc : txEcrc;
		end
	end

	// Independent of the end-to-end path, so both CRCs may be spoiled at once
	always_ff @(posedge clk) begin
		if (!resetn) begin
			txLcrcOut <= 32'h0000_0000;
		end else begin
			txLcrcOut <= lcrcBit ? ~txLcrc : txLcrc;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			txDllpValidOut <= 1'b0;
		end else begin
			txDllpValidOut <= txDllpValid;
		end
	end

	// A class miss forwards the CRC untouched
	always_ff @(posedge clk) begin
		if (!resetn) begin
			txDllpCrcOut <= 16'h0000;
		end else begin
			txDllpCrcOut <= txHit ? ~txDllpCrc : txDllpCrc;
		end
	end

	llfi_credit_adj u_adj (
		.code     (creditCode),
		.cls      (creditClass),
		.hdrIn    (creditHdr),
		.dataIn   (creditData),
		.hdrOut   (adjHdr),
		.dataOut  (adjData),
		.adjusted (adjDone)
	);

	// Credits change only when an extracted packet makes the layer advertise an update
	always_ff @(posedge clk) begin
		if (!resetn) begin
			postedCreditUpdate     <= 1'b0;
			nonpostedCreditUpdate  <= 1'b0;
			completionCreditUpdate <= 1'b0;
		end else begin
			postedCreditUpdate     <= creditEvent && (creditClass == LLFI_CLS_POSTED);
			nonpostedCreditUpdate  <= creditEvent && (creditClass == LLFI_CLS_NONPOSTED);
			completionCreditUpdate <= creditEvent && (creditClass == LLFI_CLS_COMPLETION);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			creditHdrOut  <= 8'h00;
			creditDataOut <= 12'h000;
		end else if (creditEvent) begin
			creditHdrOut  <= adjHdr;
			creditDataOut <= adjData;
		end
	end

	// Event counters wrap; software compares two reads to see activity
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rxForcedCount <= 8'h00;
		end else if (rxHit && rxDllpValid) begin
			rxForcedCount <= rxForcedCount + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			nakCount <= 8'h00;
		end else if (ackSubst) begin
			nakCount <= nakCount + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			txCorruptCount <= 8'h00;
		end else if (txHit || (txTlpValid && (ecrcBit || lcrcBit))) begin
			txCorruptCount <= txCorruptCount + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			creditAdjCount <= 8'h00;
		end else if (creditEvent && adjDone) begin
			creditAdjCount <= creditAdjCount + 8'h01;
		end
	end
endmodule : llfi_top

// [tb/llfi_checker.sv]
// Port assertions of the fault-injection block
`timescale 1ns/1ps
module llfi_checker
	import llfi_pkg::*;
(
	input wire logic      clk,
	input wire logic      resetn,
	input wire logic      avs_read,
	input wire logic      avs_write,
	input wire logic      avs_waitrequest,
	input wire logic      rxDllpValid,
	input wire logic      rxDllpCrcOk,
	input wire logic      rxDllpValidOut,
	input wire logic      rxDllpCrcError,
	input wire logic      replayStart,
	input wire logic      ackValid,
	input wire logic      ackValidOut,
	input wire logic      txTlpValid,
	input wire logic      txTlpValidOut,
	input wire logic      creditEvent,
	input wire llfi_cls_t creditClass,
	input wire logic      postedCreditUpdate,
	input wire logic      nonpostedCreditUpdate,
	input wire logic      completionCreditUpdate
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_taken;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	property p_bus; s_taken |=> s_answer; endproperty
	a_bus: assert property (p_bus) else $error("bus answer not one cycle");
	property p_rx_valid; rxDllpValid |=> rxDllpValidOut; endproperty
	a_rx_valid: assert property (p_rx_valid) else $error("rx valid lost");
	property p_rx_bad; rxDllpValid && !rxDllpCrcOk |=> rxDllpCrcError; endproperty
	a_rx_bad: assert property (p_rx_bad) else $error("bad crc not flagged");
	property p_err_valid; rxDllpCrcError |-> rxDllpValidOut; endproperty
	a_err_valid: assert property (p_err_valid) else $error("error without packet");
	property p_ack; ackValid |=> ackValidOut; endproperty
	a_ack: assert property (p_ack) else $error("ack lost");
	property p_tlp; txTlpValid |=> txTlpValidOut; endproperty
	a_tlp: assert property (p_tlp) else $error("tlp lost");
	property p_replay_pulse; replayStart |=> !replayStart; endproperty
	a_replay_pulse: assert property (p_replay_pulse) else $error("replay too long");
	// A replay may only follow a completed register write two edges back
	property p_replay_cause; replayStart |-> $past(avs_write && !avs_waitrequest, 2); endproperty
	a_replay_cause: assert property (p_replay_cause) else $error("replay uncaused");
	property p_posted; creditEvent && creditClass == LLFI_CLS_POSTED |=> postedCreditUpdate;
	endproperty
	a_posted: assert property (p_posted) else $error("posted update missing");
	property p_no_event;
		!creditEvent |=> !(postedCreditUpdate || nonpostedCreditUpdate || completionCreditUpdate);
	endproperty
	a_no_event: assert property (p_no_event) else $error("update without event");
endmodule : llfi_checker

bind llfi_top llfi_checker u_chk (.clk(clk), .resetn(resetn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .rxDllpValid(rxDllpValid),
	.rxDllpCrcOk(rxDllpCrcOk), .rxDllpValidOut(rxDllpValidOut),
	.rxDllpCrcError(rxDllpCrcError), .replayStart(replayStart), .ackValid(ackValid),
	.ackValidOut(ackValidOut), .txTlpValid(txTlpValid), .txTlpValidOut(txTlpValidOut),
	.creditEvent(creditEvent), .creditClass(creditClass),
	.postedCreditUpdate(postedCreditUpdate), .nonpostedCreditUpdate(nonpostedCreditUpdate),
	.completionCreditUpdate(completionCreditUpdate));

// [tb/llfi_host.sv]
// Bus master standing in for the test logic that sets the fault vector
`timescale 1ns/1ps
module llfi_host (
	input  wire logic        clk,
	input  wire logic        avs_waitrequest,
	input  wire logic [31:0] avs_readdata,
	output logic      [3:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata
);
	initial begin
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Released lines flip so a stale value never looks valid
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask : xfer
endmodule : llfi_host

// [tb/test_llfi_top.sv]
// Self-checking bench of the fault-injection block
`timescale 1ns/1ps
`include "llfi_consts.svh"
module test_llfi_top
	import llfi_pkg::*;
;
	logic clk = 1'b0, resetn = 1'b0, avs_read, avs_write, avs_waitrequest, replayStart;
	logic rxDllpValid, rxDllpCrcOk, rxDllpValidOut, rxDllpCrcError, ackValid, ackValidOut;
	logic ackIsNak, txTlpValid, txTlpValidOut, txDllpValid, txDllpValidOut, creditEvent;
	logic postedCreditUpdate, nonpostedCreditUpdate, completionCreditUpdate;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, txEcrc, txLcrc, txEcrcOut, txLcrcOut;
	logic [11:0] ackSeq, ackSeqOut, creditData, creditDataOut;
	logic [15:0] txDllpCrc, txDllpCrcOut;
	logic [7:0]  creditHdr, creditHdrOut;
	llfi_dllp_t  rxDllpType, txDllpType;
	llfi_cls_t   creditClass;
	int          n_errors = 0, n_checks = 0, vec = 0, x8 = 0, armed = 0, eh = 0, ed = 0;
	int          nrx = 0, nnak = 0, ntx = 0, ncr = 0;
	always #2.5 clk = ~clk;
	llfi_host host (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata));
	llfi_top dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rxDllpValid(rxDllpValid), .rxDllpType(rxDllpType),
		.rxDllpCrcOk(rxDllpCrcOk), .rxDllpValidOut(rxDllpValidOut),
		.rxDllpCrcError(rxDllpCrcError), .replayStart(replayStart), .ackValid(ackValid),
		.ackSeq(ackSeq), .ackValidOut(ackValidOut), .ackIsNak(ackIsNak), .ackSeqOut(ackSeqOut),
		.txTlpValid(txTlpValid), .txEcrc(txEcrc), .txLcrc(txLcrc), .txTlpValidOut(txTlpValidOut),
		.txEcrcOut(txEcrcOut), .txLcrcOut(txLcrcOut), .txDllpValid(txDllpValid),
		.txDllpType(txDllpType), .txDllpCrc(txDllpCrc), .txDllpValidOut(txDllpValidOut),
		.txDllpCrcOut(txDllpCrcOut), .creditEvent(creditEvent), .creditClass(creditClass),
		.creditHdr(creditHdr), .creditData(creditData), .postedCreditUpdate(postedCreditUpdate),
		.nonpostedCreditUpdate(nonpostedCreditUpdate),
		.completionCreditUpdate(completionCreditUpdate), .creditHdrOut(creditHdrOut),
		.creditDataOut(creditDataOut));
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b1, a, d, q);
		if (a == `LLFI_OFS_VECTOR) begin
			vec = d;
			armed = (d[16:15] != 2'h0);
		end
		if (a == `LLFI_OFS_CONFIG)
			x8 = d[0];
	endtask : wr
	task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		host.xfer(1'b0, a, 32'h0, q);
		chk(what, e, q);
	endtask : rdc
	// Credit code table: class 3 means no adjustment
	function automatic void cred(input int c, output int cls, output int dh, output int dd);
		cls = 3;
		dh = 0;
		dd = 0;
		if (c >= 1 && c <= 18) begin
			cls = ((c - 1) % 9) / 3;
			dh = ((c - 1) % 3 != 1) ? 1 : 0;
			dd = ((c - 1) % 3 != 0) ? 1 : 0;
			if (c > 9) begin
				dh = -dh;
				dd = -dd;
			end
		end else if (c >= 19 && c <= 24) begin
			cls = (c - 19) / 2;
			dh = (c % 2) ? 1 : -1;
			dd = -dh;
		end
	endfunction : cred
	task automatic step();
		logic rv, rok, av, tv, dv, ce, hit;
		logic [1:0] rt, dt, cc, fr, fa, ft;
		logic [7:0] ch;
		logic [11:0] sq, cd, es;
		logic [15:0] dc;
		logic [31:0] ec, lc, m;
		int cls, dh, dd;
		m = x8 ? vec & 32'hFF10_7FFF : vec;
		{rv, rok, av, tv, dv, ce, rt, dt, cc} = $urandom;
		{ch, sq, cd} = {$urandom, $urandom};
		{dc, ec, lc} = {$urandom, $urandom, $urandom};
		{fr, fa, ft} = {m[16:15], m[19:18], m[23:22]};
		@(posedge clk);
		{rxDllpValid, rxDllpCrcOk, ackValid, txTlpValid, txDllpValid, creditEvent} <=
			{rv, rok, av, tv, dv, ce};
		rxDllpType <= llfi_dllp_t'(rt);
		txDllpType <= llfi_dllp_t'(dt);
		creditClass <= llfi_cls_t'(cc);
		{ackSeq, txEcrc, txLcrc, txDllpCrc, creditHdr, creditData} <= {sq, ec, lc, dc, ch, cd};
		@(posedge clk);
		{rxDllpValid, ackValid, txTlpValid, txDllpValid, creditEvent} <= 5'h00;
		{ackSeq, txEcrc, txLcrc, txDllpCrc} <= ~{sq, ec, lc, dc};
		hit = rv && armed && fr != 2'h0 && rt == fr - 2'h1;
		if (hit)
			armed = 0;
		cred(m[28:24], cls, dh, dd);
		if (ce) begin
			eh = (ch + ((cls == cc) ? dh : 0)) & 255;
			ed = (cd + ((cls == cc) ? dd : 0)) & 4095;
		end
		es = (fa == 2'h2) ? sq + 12'h001 : (fa == 2'h3) ? sq - 12'h001 : sq;
		nrx += hit;
		nnak += av && fa != 2'h0;
		ntx += (dv && ft != 2'h0 && dt == ft % 3) || (tv && (m[20] || m[21]));
		ncr += ce && cls != 3 && cls == cc;
		#1;
		chk("rx valid", rv, rxDllpValidOut);
		chk("rx crc error", rv && (!rok || hit), rxDllpCrcError);
		chk("ack valid", av, ackValidOut);
		chk("tx valids", {tv, dv}, {txTlpValidOut, txDllpValidOut});
		if (av)
			chk("nak", {fa != 2'h0, es}, {ackIsNak, ackSeqOut});
		if (tv)
			chk("ecrc", ec ^ {32{m[20]}}, txEcrcOut);
		if (tv)
			chk("lcrc", lc ^ {32{m[21]}}, txLcrcOut);
		if (dv)
			chk("dllp crc", dc ^ {16{ft != 2'h0 && dt == ft % 3}}, txDllpCrcOut);
		chk("update pulses", {3{ce}} & (3'h1 << cc), {completionCreditUpdate,
			nonpostedCreditUpdate, postedCreditUpdate});
		chk("credit", {eh[7:0], ed[11:0]}, {creditHdrOut, creditDataOut});
	endtask : step
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		close_out();
	end
	initial begin
		logic [4:0] c;
		logic [31:0] v;
		{rxDllpValid, rxDllpCrcOk, ackValid, txTlpValid, txDllpValid, creditEvent} = 6'h00;
		{ackSeq, creditHdr, creditData} = 0;
		rxDllpType = LLFI_DLLP_OTHER;
		txDllpType = LLFI_DLLP_OTHER;
		creditClass = LLFI_CLS_NONE;
		{txEcrc, txLcrc, txDllpCrc} = 0;
		void'($urandom(32'h419667dd));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		chk("reset outputs", 32'h1, {replayStart, rxDllpCrcError, ackIsNak, avs_waitrequest});
		rdc("status", `LLFI_OFS_STATUS, 32'h0);
		rdc("config", `LLFI_OFS_CONFIG, 32'h0);
		$display("test reset done");
		v = $urandom;
		wr(`LLFI_OFS_VECTOR, v);
		rdc("vector", `LLFI_OFS_VECTOR, v);
		wr(`LLFI_OFS_VECTOR, 32'h0001_8000);
		wr(`LLFI_OFS_CONFIG, 32'hFFFF_FFFE);
		rdc("armed", `LLFI_OFS_CONFIG, 32'h0000_0100);
		wr(4'hC, 32'hFFFF_FFFF);
		rdc("unmapped", 4'hC, 32'h0);
		wr(`LLFI_OFS_VECTOR, 32'h0);
		rdc("disarmed", `LLFI_OFS_CONFIG, 32'h0);
		$display("test registers done");
		for (int x = 0; x < 2; x++) begin
			wr(`LLFI_OFS_CONFIG, x);
			for (int k = 0; k < 32; k++) begin
				c = k;
				v = {3'h0, c, c[1:0], c[3], c[2], c[1:0], 1'b0, c[1:0], 15'h0000};
				wr(`LLFI_OFS_VECTOR, v);
				repeat (6) step();
				wr(`LLFI_OFS_VECTOR, v | 32'h0002_0000);
				@(posedge clk);
				#1;
				chk("replay", !x8, replayStart);
				@(posedge clk);
				#1;
				chk("replay end", 0, replayStart);
			end
			$display("test codes done");
		end
		rdc("status", `LLFI_OFS_STATUS, {ncr[7:0], ntx[7:0], nnak[7:0], nrx[7:0]});
		wr(`LLFI_OFS_VECTOR, 32'h0);
		close_out();
	end
endmodule : test_llfi_top
